/* File: shared/bpm_defines.vh */
// How it works
// RULE_01: Zero redundancy field uses detected swap map
// RULE_02: Selector codes map pools; fifteen reserved
// RULE_03: All-pools bit selects every pool
// RULE_04: Pool reset fires on trigger rising edge
// RULE_05: Software stops grant/release before pool reset
// RULE_06: Software reprograms free list, clears queue control
// RULE_07: Head pointer split low byte, high seven
// RULE_08: Tail pointer split low byte, high seven
// RULE_09: Granule count split low byte, high seven
// RULE_10: Upper bit seven commits on rising edge
// RULE_11: Software-linked: write memory, then pointers, count
// RULE_12: Zero head/tail plus count starts hardware linking
// RULE_13: Pop release entry on rising request, nonempty
// RULE_14: Info byte layout for head/tail pointer bits
// RULE_15: Release count split across bytes four, five
// RULE_16: Multicast flag in fifth byte bit five
// RULE_17: Source port and class in bytes five, six
// RULE_18: Queue-manager origin flag in sixth byte
// RULE_19: Sixth byte top bits give FIFO depth
// RULE_20: Queue control bits stop grant and release
// RULE_21: Head low byte first, tail middle third
`ifndef BPM_DEFINES_VH
`define BPM_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BPM_ADDR_W          12
`define BPM_OFF_QUEUE_CONTROL       12'heba
`define BPM_OFF_BIST_LO     12'hebb
`define BPM_OFF_BIST_HI     12'hebc
`define BPM_OFF_REDUND      12'hebd
`define BPM_OFF_POOL_RST    12'hec0
`define BPM_OFF_HEAD_LO     12'hec1
`define BPM_OFF_HEAD_HI     12'hec2
`define BPM_OFF_TAIL_LO     12'hec3
`define BPM_OFF_TAIL_HI     12'hec4
`define BPM_OFF_CNT_LO      12'hec5
`define BPM_OFF_CNT_HI      12'hec6
`define BPM_OFF_POP_CTRL    12'hec7
`define BPM_OFF_INFO0       12'hec8
`define BPM_OFF_INFO1       12'hec9
`define BPM_OFF_INFO2       12'heca
`define BPM_OFF_INFO3       12'hecb
`define BPM_OFF_INFO4       12'hecc
`define BPM_OFF_INFO5       12'hecd

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define BPM_PTR_W           15
`define BPM_NPOOL           15
`define BPM_POOL_SEL_RSVD   4'hf
`define BPM_POOL_ALL_BIT    4
`define BPM_POOL_TRIG_BIT   5
`define BPM_COMMIT_BIT      7
`define BPM_POP_BIT         0
`define BPM_QC_STOP_QM      0
`define BPM_QC_STOP_MCQ     1
`define BPM_QC_STOP_GRANT   2
`define BPM_QC_STOP_REL     3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPM_RST_BYTE        8'h00
`define BPM_RST_PTR         15'h0000

`endif

/* File: design/bpm_regs.v */
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "bpm_defines.vh"

module bpm_regs (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_reset,
  // Register port
  input  wire [11:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // Memory redundancy and self-test
  input  wire [15:0] i_selftest_result,
  input  wire [3:0]  i_hw_swap_map,
  output reg  [3:0]  o_swap_map,
  // Queue control
  output reg         o_stop_qm_idle,
  output reg         o_stop_mcq_idle,
  output reg         o_stop_grant,
  output reg         o_stop_release,
  // Pool reset
  output reg         o_pool_reset,
  output reg  [14:0] o_pool_reset_mask,
  // Free list programming
  output reg         o_head_load,
  output reg  [14:0] o_head_ptr,
  output reg         o_tail_load,
  output reg  [14:0] o_tail_ptr,
  output reg         o_count_load,
  output reg  [14:0] o_granule_count,
  output reg         o_hw_link_start,
  // Release FIFO, show-ahead head entry
  input  wire [2:0]  i_rls_entries,
  input  wire [14:0] i_rls_head_ptr,
  input  wire [14:0] i_rls_tail_ptr,
  input  wire [6:0]  i_rls_count,
  input  wire        i_rls_mcast,
  input  wire [3:0]  i_rls_src_port,
  input  wire [1:0]  i_rls_class,
  input  wire        i_rls_from_qm,
  output reg         o_rls_pop
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Code 15 selects nothing unless the all-pools bit is set
  function [14:0] pool_mask;
    input [3:0] sel;
    input       all;
    begin
      if (all) begin
        pool_mask = {`BPM_NPOOL{1'b1}};  // RULE_03
      end else if (sel == `BPM_POOL_SEL_RSVD) begin
        pool_mask = 15'h0000;  // RULE_02
      end else begin
        pool_mask = 15'h0001 << sel;  // RULE_02
      end
    end
  endfunction

  // ----------------------------------------
  // Software-written state
  // ----------------------------------------
  reg [3:0] queue_control_q;
  reg [3:0] redund_q;
  reg [5:0] pool_rst_q;
  reg [7:0] head_lo_q;
  reg [7:0] head_hi_q;
  reg [7:0] tail_lo_q;
  reg [7:0] tail_hi_q;
  reg [7:0] cnt_lo_q;
  reg [7:0] cnt_hi_q;
  reg       pop_req_q;

  // Captured release entry
  reg [14:0] rls_head_q;
  reg [14:0] rls_tail_q;
  reg [6:0]  rls_count_q;
  reg        rls_mcast_q;
  reg [3:0]  rls_src_q;
  reg [1:0]  rls_class_q;
  reg        rls_qm_q;

  wire wr_queue_control  = i_wr & hit(i_addr, `BPM_OFF_QUEUE_CONTROL);
  wire wr_redund = i_wr & hit(i_addr, `BPM_OFF_REDUND);
  wire wr_prst   = i_wr & hit(i_addr, `BPM_OFF_POOL_RST);
  wire wr_hlo    = i_wr & hit(i_addr, `BPM_OFF_HEAD_LO);
  wire wr_hhi    = i_wr & hit(i_addr, `BPM_OFF_HEAD_HI);
  wire wr_tlo    = i_wr & hit(i_addr, `BPM_OFF_TAIL_LO);
  wire wr_thi    = i_wr & hit(i_addr, `BPM_OFF_TAIL_HI);
  wire wr_clo    = i_wr & hit(i_addr, `BPM_OFF_CNT_LO);
  wire wr_chi    = i_wr & hit(i_addr, `BPM_OFF_CNT_HI);
  wire wr_pop    = i_wr & hit(i_addr, `BPM_OFF_POP_CTRL);

  // Edge triggers: bit goes from stored 0 to written 1
  wire prst_rise = wr_prst & i_wdata[`BPM_POOL_TRIG_BIT] & ~pool_rst_q[`BPM_POOL_TRIG_BIT];  // RULE_04
  wire hcom_rise = wr_hhi & i_wdata[`BPM_COMMIT_BIT] & ~head_hi_q[`BPM_COMMIT_BIT];  // RULE_10
  wire tcom_rise = wr_thi & i_wdata[`BPM_COMMIT_BIT] & ~tail_hi_q[`BPM_COMMIT_BIT];  // RULE_10
  wire ccom_rise = wr_chi & i_wdata[`BPM_COMMIT_BIT] & ~cnt_hi_q[`BPM_COMMIT_BIT];  // RULE_10
  wire pop_rise  = wr_pop & i_wdata[`BPM_POP_BIT] & ~pop_req_q;
  // Empty FIFO swallows the request; software must toggle again
  wire pop_go    = pop_rise & (i_rls_entries != 3'h0);  // RULE_13

  wire [14:0] head_val = {head_hi_q[6:0], head_lo_q};  // RULE_07
  wire [14:0] tail_val = {tail_hi_q[6:0], tail_lo_q};  // RULE_08
  wire [14:0] cnt_val  = {i_wdata[6:0], cnt_lo_q};  // RULE_09

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      queue_control_q    <= 4'h0;
      redund_q   <= 4'h0;
      pool_rst_q <= 6'h00;
      head_lo_q  <= `BPM_RST_BYTE;
      head_hi_q  <= `BPM_RST_BYTE;
      tail_lo_q  <= `BPM_RST_BYTE;
      tail_hi_q  <= `BPM_RST_BYTE;
      cnt_lo_q   <= `BPM_RST_BYTE;
      cnt_hi_q   <= `BPM_RST_BYTE;
      pop_req_q  <= 1'b0;
    end else begin
      if (wr_queue_control) begin
        queue_control_q <= i_wdata[3:0];
      end
      if (wr_redund) begin
        redund_q <= i_wdata[3:0];
      end
      if (wr_prst) begin
        pool_rst_q <= i_wdata[5:0];
      end
      if (wr_hlo) begin
        head_lo_q <= i_wdata;
      end
      if (wr_hhi) begin
        head_hi_q <= i_wdata;
      end
      if (wr_tlo) begin
        tail_lo_q <= i_wdata;
      end
      if (wr_thi) begin
        tail_hi_q <= i_wdata;
      end
      if (wr_clo) begin
        cnt_lo_q <= i_wdata;
      end
      if (wr_chi) begin
        cnt_hi_q <= i_wdata;
      end
      if (wr_pop) begin
        pop_req_q <= i_wdata[`BPM_POP_BIT];
      end
    end
  end

  // ----------------------------------------
  // Control outputs toward buffer manager
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_swap_map        <= 4'h0;
      o_stop_qm_idle    <= 1'b0;
      o_stop_mcq_idle   <= 1'b0;
      o_stop_grant      <= 1'b0;
      o_stop_release    <= 1'b0;
      o_pool_reset      <= 1'b0;
      o_pool_reset_mask <= 15'h0000;
      o_head_load       <= 1'b0;
      o_head_ptr        <= `BPM_RST_PTR;
      o_tail_load       <= 1'b0;
      o_tail_ptr        <= `BPM_RST_PTR;
      o_count_load      <= 1'b0;
      o_granule_count   <= `BPM_RST_PTR;
      o_hw_link_start   <= 1'b0;
      o_rls_pop         <= 1'b0;
    end else begin
      // Detected map is tracked live until software overrides it
      o_swap_map      <= (redund_q == 4'h0) ? i_hw_swap_map : redund_q;  // RULE_01
      o_stop_qm_idle  <= queue_control_q[`BPM_QC_STOP_QM];
      o_stop_mcq_idle <= queue_control_q[`BPM_QC_STOP_MCQ];
      o_stop_grant    <= queue_control_q[`BPM_QC_STOP_GRANT];  // RULE_20
      o_stop_release  <= queue_control_q[`BPM_QC_STOP_REL];  // RULE_20
      o_pool_reset    <= prst_rise;  // RULE_04
      if (prst_rise) begin
        o_pool_reset_mask <= pool_mask(i_wdata[3:0], i_wdata[`BPM_POOL_ALL_BIT]);  // RULE_03
      end
      // Commit takes the upper bits from the same write
      o_head_load <= hcom_rise;  // RULE_10
      if (hcom_rise) begin
        o_head_ptr <= {i_wdata[6:0], head_lo_q};  // RULE_07
      end
      o_tail_load <= tcom_rise;  // RULE_10
      if (tcom_rise) begin
        o_tail_ptr <= {i_wdata[6:0], tail_lo_q};  // RULE_08
      end
      o_count_load <= ccom_rise;  // RULE_10
      if (ccom_rise) begin
        o_granule_count <= cnt_val;  // RULE_09
      end
      // Both pointers zero means the manager links the list itself
      o_hw_link_start <= ccom_rise & (head_val == 15'h0000) & (tail_val == 15'h0000);  // RULE_12
      o_rls_pop       <= pop_go;  // RULE_13
    end
  end

  // ----------------------------------------
  // Release entry capture
  // ----------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      rls_head_q  <= `BPM_RST_PTR;
      rls_tail_q  <= `BPM_RST_PTR;
      rls_count_q <= 7'h00;
      rls_mcast_q <= 1'b0;
      rls_src_q   <= 4'h0;
      rls_class_q <= 2'h0;
      rls_qm_q    <= 1'b0;
    end else if (pop_go) begin
      rls_head_q  <= i_rls_head_ptr;  // RULE_13
      rls_tail_q  <= i_rls_tail_ptr;
      rls_count_q <= i_rls_count;
      rls_mcast_q <= i_rls_mcast;
      rls_src_q   <= i_rls_src_port;
      rls_class_q <= i_rls_class;
      rls_qm_q    <= i_rls_from_qm;
    end
  end

  // ----------------------------------------
  // Read mux, data one cycle after strobe
  // ----------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (i_addr)
      `BPM_OFF_QUEUE_CONTROL:    rd_mux = {4'h0, queue_control_q};
      `BPM_OFF_BIST_LO:  rd_mux = i_selftest_result[7:0];
      `BPM_OFF_BIST_HI:  rd_mux = i_selftest_result[15:8];
      `BPM_OFF_REDUND:   rd_mux = {4'h0, redund_q};
      `BPM_OFF_POOL_RST: rd_mux = {2'h0, pool_rst_q};
      `BPM_OFF_HEAD_LO:  rd_mux = head_lo_q;  // RULE_07
      `BPM_OFF_HEAD_HI:  rd_mux = head_hi_q;  // RULE_07
      `BPM_OFF_TAIL_LO:  rd_mux = tail_lo_q;  // RULE_08
      `BPM_OFF_TAIL_HI:  rd_mux = tail_hi_q;  // RULE_08
      `BPM_OFF_CNT_LO:   rd_mux = cnt_lo_q;  // RULE_09
      `BPM_OFF_CNT_HI:   rd_mux = cnt_hi_q;  // RULE_09
      `BPM_OFF_POP_CTRL: rd_mux = {7'h00, pop_req_q};
      `BPM_OFF_INFO0:    rd_mux = rls_head_q[7:0];  // RULE_21
      `BPM_OFF_INFO1:    rd_mux = {rls_tail_q[0], rls_head_q[14:8]};  // RULE_14
      `BPM_OFF_INFO2:    rd_mux = rls_tail_q[8:1];  // RULE_21
      `BPM_OFF_INFO3:    rd_mux = {rls_count_q[1:0], rls_tail_q[14:9]};  // RULE_15
      `BPM_OFF_INFO4:    rd_mux = {rls_src_q[1:0], rls_mcast_q, rls_count_q[6:2]};  // RULE_15 RULE_16 RULE_17
      // Depth is live, not frozen at the last pop
      `BPM_OFF_INFO5:    rd_mux = {i_rls_entries, rls_qm_q, rls_class_q, rls_src_q[3:2]};  // RULE_17 RULE_18 RULE_19
      default:           rd_mux = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_mux;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // bpm_regs

`default_nettype wire

/* File: dv/bpm_regs_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bpm_defines.vh"

module bpm_chk (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  // Register port
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [11:0] i_addr,
  input wire logic [7:0]  i_wdata,
  // Release FIFO depth
  input wire logic [2:0]  i_rls_entries,
  // Watched outputs
  input wire logic        o_stop_grant,
  input wire logic        o_stop_release,
  input wire logic        o_pool_reset,
  input wire logic        o_head_load,
  input wire logic        o_tail_load,
  input wire logic        o_count_load,
  input wire logic        o_hw_link_start,
  input wire logic        o_rls_pop,
  input wire logic [14:0] o_pool_reset_mask,
  input wire logic [14:0] o_head_ptr,
  input wire logic [14:0] o_tail_ptr,
  input wire logic [14:0] o_granule_count
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire w_pool = i_wr && (i_addr == `BPM_OFF_POOL_RST);
  wire w_hhi  = i_wr && (i_addr == `BPM_OFF_HEAD_HI);
  wire w_thi  = i_wr && (i_addr == `BPM_OFF_TAIL_HI);
  wire w_chi  = i_wr && (i_addr == `BPM_OFF_CNT_HI);
  wire w_pop  = i_wr && (i_addr == `BPM_OFF_POP_CTRL);
  wire w_qc   = i_wr && (i_addr == `BPM_OFF_QUEUE_CONTROL);
  // ----------------------------------------
  // Side effects tied to their writes
  // ----------------------------------------
  a_pool_cause: assert property (o_pool_reset |-> $past(w_pool) && $past(i_wdata[5]))
    else $error("pool reset without trigger write");
  a_pool_once: assert property (o_pool_reset |=> !o_pool_reset)
    else $error("pool reset pulse too long");
  a_pool_all: assert property (o_pool_reset && $past(i_wdata[4]) |-> o_pool_reset_mask == 15'h7fff)
    else $error("all-pools mask wrong");
  a_pool_sel: assert property (o_pool_reset && !$past(i_wdata[4])
    |-> o_pool_reset_mask == (15'h0001 << $past(i_wdata[3:0])))
    else $error("pool selector mask wrong");
  a_mask_hold: assert property (!o_pool_reset |-> $stable(o_pool_reset_mask))
    else $error("pool mask moved without pulse");
  a_head_load: assert property (o_head_load
    |-> $past(w_hhi) && $past(i_wdata[7]) && o_head_ptr[14:8] == $past(i_wdata[6:0]))
    else $error("head commit wrong");
  a_tail_load: assert property (o_tail_load
    |-> $past(w_thi) && $past(i_wdata[7]) && o_tail_ptr[14:8] == $past(i_wdata[6:0]))
    else $error("tail commit wrong");
  a_count_load: assert property (o_count_load
    |-> $past(w_chi) && $past(i_wdata[7]) && o_granule_count[14:8] == $past(i_wdata[6:0]))
    else $error("count commit wrong");
  a_load_gap: assert property (o_count_load |=> !o_count_load)
    else $error("count commit pulse too long");
  a_link_start: assert property (o_hw_link_start |-> o_count_load)
    else $error("link start without count commit");
  a_pop_cause: assert property (o_rls_pop
    |-> $past(w_pop) && $past(i_wdata[0]) && $past(i_rls_entries) != 3'h0)
    else $error("pop without request or on empty fifo");
  // Stop levels pass through the stored copy, so they lag the write by two edges
  a_stop_bits: assert property ($past(w_qc, 2)
    |-> o_stop_grant == $past(i_wdata[2], 2) && o_stop_release == $past(i_wdata[3], 2))
    else $error("stop levels wrong");
  c_all_pools: cover property (o_pool_reset && o_pool_reset_mask == 15'h7fff);
  c_link: cover property (o_hw_link_start);
  c_pop: cover property (o_rls_pop);
endmodule // bpm_chk

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bpm_defines.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module tb_top;
  logic        i_clk_sys = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_rls_mcast = 1'b0, i_rls_from_qm = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0]  i_wdata = 8'h00, o_rdata, rv;
  logic [15:0] i_selftest_result = 16'ha53c;
  logic [3:0]  i_hw_swap_map = 4'h6, i_rls_src_port = 4'h0, o_swap_map;
  logic [2:0]  i_rls_entries = 3'h0;
  logic [14:0] i_rls_head_ptr = 15'h0000, i_rls_tail_ptr = 15'h0000;
  logic [14:0] o_pool_reset_mask, o_head_ptr, o_tail_ptr, o_granule_count;
  logic [6:0]  i_rls_count = 7'h00;
  logic [1:0]  i_rls_class = 2'h0;
  logic        o_stop_qm_idle, o_stop_mcq_idle, o_stop_grant, o_stop_release, o_pool_reset;
  logic        o_head_load, o_tail_load, o_count_load, o_hw_link_start, o_rls_pop;
  int          mismatches = 0, samples_checked = 0, n_pool = 0, n_cnt = 0, n_link = 0, n_pop = 0, n_ld = 0;

  bpm_regs bpm_regs_inst (.*);

  always #10 i_clk_sys = ~i_clk_sys;
  // Pulses are one cycle wide, so count them at every edge
  always @(posedge i_clk_sys) begin
    n_pool += o_pool_reset;
    n_cnt += o_count_load;
    n_link += o_hw_link_start;
    n_pop += o_rls_pop;
    n_ld += o_head_load + o_tail_load;
  end
  // ----------------------------------------
  // Register port tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rv = o_rdata;
    `CHK("rdata", e, rv)
  endtask
  task automatic settle;
    repeat (2) @(negedge i_clk_sys);
  endtask
  task automatic t_reset;
    for (int a = 'hec0; a <= 'hecd; a++) rchk(a[11:0], 8'h00);
    rchk(`BPM_OFF_QUEUE_CONTROL, 8'h00);
    rchk(`BPM_OFF_BIST_LO, 8'h3c);
    rchk(`BPM_OFF_BIST_HI, 8'ha5);
    wr(12'hebe, 8'hff);
    rchk(12'hebe, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_redund;
    wr(`BPM_OFF_REDUND, 8'hf9);
    settle;
    `CHK("swap_map", 4'h9, o_swap_map)
    rchk(`BPM_OFF_REDUND, 8'h09);
    wr(`BPM_OFF_REDUND, 8'h00);
    @(posedge i_clk_sys);
    i_hw_swap_map <= 4'h3;
    settle;
    `CHK("swap_map", 4'h3, o_swap_map)
    $display("t_redund done");
  endtask
  task automatic t_queue_control;
    wr(`BPM_OFF_QUEUE_CONTROL, 8'hfc);
    settle;
    `CHK("stops", 4'hc, {o_stop_release, o_stop_grant, o_stop_mcq_idle, o_stop_qm_idle})
    rchk(`BPM_OFF_QUEUE_CONTROL, 8'h0c);
    $display("t_queue_control done");
  endtask
  task automatic t_pool;
    for (int c = 0; c < 16; c++) begin
      wr(`BPM_OFF_POOL_RST, 8'h20 | c[7:0]);
      wr(`BPM_OFF_POOL_RST, 8'h20 | c[7:0]);
      settle;
      `CHK("pool_mask", 15'h0001 << c, o_pool_reset_mask)
      `CHK("pool_pulses", c + 1, n_pool)
      wr(`BPM_OFF_POOL_RST, c[7:0]);
    end
    wr(`BPM_OFF_POOL_RST, 8'hf2);
    settle;
    `CHK("pool_mask", 15'h7fff, o_pool_reset_mask)
    rchk(`BPM_OFF_POOL_RST, 8'h32);
    $display("t_pool done");
  endtask
  task automatic t_free;
    wr(`BPM_OFF_HEAD_LO, 8'h34);
    wr(`BPM_OFF_HEAD_HI, 8'hd2);
    wr(`BPM_OFF_TAIL_LO, 8'hff);
    wr(`BPM_OFF_TAIL_HI, 8'hff);
    wr(`BPM_OFF_CNT_LO, 8'h01);
    wr(`BPM_OFF_CNT_HI, 8'h80);
    wr(`BPM_OFF_CNT_HI, 8'h80);
    settle;
    `CHK("head", 15'h5234, o_head_ptr)
    `CHK("tail", 15'h7fff, o_tail_ptr)
    `CHK("count", 15'h0001, o_granule_count)
    `CHK("commits", 1, n_cnt)
    `CHK("ptr_loads", 2, n_ld)
    `CHK("links", 0, n_link)
    rchk(`BPM_OFF_HEAD_HI, 8'hd2);
    for (int a = 'hec1; a <= 'hec4; a++) wr(a[11:0], 8'h00);
    wr(`BPM_OFF_CNT_HI, 8'h00);
    wr(`BPM_OFF_CNT_LO, 8'h00);
    wr(`BPM_OFF_CNT_HI, 8'hc0);
    settle;
    `CHK("count", 15'h4000, o_granule_count)
    `CHK("commits", 2, n_cnt)
    `CHK("ptr_loads", 2, n_ld)
    `CHK("links", 1, n_link)
    $display("t_free done");
  endtask
  task automatic t_pop;
    logic [14:0] hp = 15'h5a3c;
    logic [14:0] tp = 15'h6b2d;
    logic [6:0]  rc = 7'h5b;
    logic [3:0]  sp = 4'hb;
    wr(`BPM_OFF_POP_CTRL, 8'h01);
    settle;
    `CHK("pops", 0, n_pop)
    rchk(`BPM_OFF_POP_CTRL, 8'h01);
    @(posedge i_clk_sys);
    {i_rls_entries, i_rls_head_ptr, i_rls_tail_ptr, i_rls_count} <= {3'h5, hp, tp, rc};
    {i_rls_mcast, i_rls_src_port, i_rls_class, i_rls_from_qm} <= {1'b1, sp, 2'h2, 1'b1};
    wr(`BPM_OFF_POP_CTRL, 8'h00);
    wr(`BPM_OFF_POP_CTRL, 8'h01);
    settle;
    `CHK("pops", 1, n_pop)
    rchk(`BPM_OFF_INFO0, hp[7:0]);
    rchk(`BPM_OFF_INFO1, {tp[0], hp[14:8]});
    rchk(`BPM_OFF_INFO2, tp[8:1]);
    rchk(`BPM_OFF_INFO3, {rc[1:0], tp[14:9]});
    rchk(`BPM_OFF_INFO4, {sp[1:0], 1'b1, rc[6:2]});
    rchk(`BPM_OFF_INFO5, {3'h5, 1'b1, 2'h2, sp[3:2]});
    @(posedge i_clk_sys);
    {i_rls_entries, i_rls_head_ptr, i_rls_from_qm} <= {3'h2, 15'h0000, 1'b0};
    wr(`BPM_OFF_POP_CTRL, 8'h01);
    settle;
    `CHK("pops", 1, n_pop)
    rchk(`BPM_OFF_INFO0, hp[7:0]);
    rchk(`BPM_OFF_INFO5, {3'h2, 1'b1, 2'h2, sp[3:2]});
    $display("t_pop done");
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_reset;
    t_redund;
    t_queue_control;
    wr(`BPM_OFF_QUEUE_CONTROL, 8'h0c);
    t_pool;
    t_free;
    wr(`BPM_OFF_QUEUE_CONTROL, 8'h00);
    t_pop;
    results;
  end
  initial begin
    #200000;
    mismatches++;
    results;
  end
endmodule // tb_top

bind bpm_regs bpm_chk bpm_chk_inst (.*);

`default_nettype wire
